// ===== inc/mfs_defines.svh
// Constants of the modem fault supervisor: times, counts, reset values.
// Assumes a 50 MHz mclk; safe with several includers per compilation unit (guarded).
// Function
// - Reset type 1 cycles module power.
// - Reset type 0 keeps module power on.
// - Query reports reset type as 1 or 0.
// - Hang interval 0..255 minutes, 0 disables, readable.
// - Nonzero interval: check hang, reset on hang.
// - Input supply bad: emergency one, power off.
// - Emergency one: lamp steadily on.
// - Leave emergency one when input supply returns.
// - Module supply bad: emergency two, power off.
// - Emergency two: lamp 0.5 s on/off.
// - Recover only if supply returns within 10 s.
// - Still bad after 10 s: waiting mode.
// - Waiting mode keeps the causing lamp pattern.
// - Only power-on reset leaves waiting mode.
// - Module fails to start: emergency three.
// - Confirm emergency three after 15 s.
// - Emergency three: 0.25 on/off/on, 1 s off.
// - Keep retrying launch until it succeeds, 10 tries at most.
// - After 10 failed launches: waiting mode.
`ifndef MFS_DEFINES_SVH
`define MFS_DEFINES_SVH

// ****************************************************************
// Clock and timebase.
// ****************************************************************
`define MFS_CLK_HZ 50000000
`define MFS_QTR_MS 250
`define MFS_MIN_S 60

// ****************************************************************
// Emergency and reset timing, in their own units.
// ****************************************************************
`define MFS_E2_WIN_S 10
`define MFS_E3_CONF_S 15
`define MFS_RST_HOLD_MS 1000
`define MFS_LAMP_HALF_MS 500
`define MFS_LAUNCH_MAX 10

// ****************************************************************
// Reset values of the settings.
// ****************************************************************
`define MFS_RTYPE_RST 1'b1
`define MFS_IVAL_RST 8'h00

`endif

// ===== inc/mfs_pkg.sv
// Types shared by the modem fault supervisor modules.
// Assumes mfs_defines.svh is available on the include path.
package mfs_pkg;

    // Top-level states of the supervisor.
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_RST = 3'b001,
        ST_LAUNCH = 3'b010,
        ST_EMER1 = 3'b011,
        ST_EMER2 = 3'b100,
        ST_WAIT = 3'b101
    } mfs_state_t;

    // Lamp patterns.
    typedef enum logic [1:0] {
        PAT_OFF = 2'b00,
        PAT_STEADY = 2'b01,
        PAT_BLINK2 = 2'b10,
        PAT_BLINK3 = 2'b11
    } mfs_pat_t;

    // Command kinds.
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_SET_RTYPE = 3'b001,
        CMD_GET_RTYPE = 3'b010,
        CMD_SET_IVAL = 3'b011,
        CMD_GET_IVAL = 3'b100,
        CMD_DO_RESET = 3'b101
    } mfs_cmd_kind_t;

    // Command from the configuration logic.
    typedef struct packed {
        logic valid;
        mfs_cmd_kind_t kind;
        logic [7:0] arg;
    } mfs_cmd_t;

    // Answer to a command.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mfs_resp_t;

endpackage : mfs_pkg

// ===== src/mfs_timebase.sv
// Quarter-second and minute tick generator.
// Assumes a free-running mclk; ticks are one-cycle pulses.
`include "mfs_defines.svh"
module mfs_timebase import mfs_pkg::*; #(
    parameter int QTR_CYCLES = 12500000
) (
    input wire logic mclk,
    input wire logic reset_n,
    output logic qtick,
    output logic min_tick
);

    // Quarters in one minute.
    localparam logic [7:0] QPM = 8'(`MFS_MIN_S * 1000 / `MFS_QTR_MS);

    // Refuse a divider that cannot produce a pulse.
    if (QTR_CYCLES < 2) begin : g_chk
        $error("QTR_CYCLES must be at least 2");
    end

    logic [31:0] div_q, div_d; // Cycle divider.
    logic [7:0] qcnt_q, qcnt_d; // Quarters within the minute.
    logic qtick_d, min_d; // Next tick values.

    // ****************************************************************
    // Divider next state.
    // ****************************************************************
    always_comb begin
        div_d = div_q + 32'h1;
        qcnt_d = qcnt_q;
        qtick_d = 1'b0;
        min_d = 1'b0;
        if (div_q == 32'(QTR_CYCLES - 1)) begin
            div_d = 32'h0;
            qtick_d = 1'b1;
            if (qcnt_q == QPM - 8'h1) begin
                qcnt_d = 8'h0;
                min_d = 1'b1;
            end else begin
                qcnt_d = qcnt_q + 8'h1;
            end
        end
    end

    // Register the divider and ticks.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 32'h0;
            qcnt_q <= 8'h0;
            qtick <= 1'b0;
            min_tick <= 1'b0;
        end else begin
            div_q <= div_d;
            qcnt_q <= qcnt_d;
            qtick <= qtick_d;
            min_tick <= min_d;
        end
    end

endmodule : mfs_timebase

// ===== src/mfs_lamp.sv
// Red fault lamp pattern generator, stepping on quarter-second ticks.
// Assumes qtick is a one-cycle pulse every 0.25 s.
`include "mfs_defines.svh"
module mfs_lamp import mfs_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire mfs_pat_t pat,
    input wire logic qtick,
    output logic lamp
);

    // Quarters in one blink half period.
    localparam logic [2:0] HALF_Q = 3'(`MFS_LAMP_HALF_MS / `MFS_QTR_MS);

    mfs_pat_t pat_q; // Pattern seen last cycle, restarts the sequence.
    logic [2:0] step_q, step_d; // Position within the pattern.
    logic lamp_d; // Next lamp level.

    // Last quarter step of one period of a pattern, one less than its number of steps.
    function automatic logic [2:0] period(input mfs_pat_t p);
        case (p)
            PAT_BLINK2: period = 3'(2 * HALF_Q - 3'h1);
            PAT_BLINK3: period = 3'h6;
            default: period = 3'h0;
        endcase
    endfunction : period

    // ****************************************************************
    // Step counter and lamp level.
    // ****************************************************************
    always_comb begin
        step_d = step_q;
        if (pat != pat_q) begin
            step_d = 3'h0;
        end else if (qtick) begin
            step_d = (step_q >= period(pat)) ? 3'h0 : step_q + 3'h1;
        end
        case (pat)
            PAT_STEADY: lamp_d = 1'b1;
            PAT_BLINK2: lamp_d = (step_d < HALF_Q);
            // Two short flashes then one second dark.
            PAT_BLINK3: lamp_d = (step_d == 3'h0) || (step_d == 3'h2);
            default: lamp_d = 1'b0;
        endcase
    end

    // Register step and lamp.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pat_q <= PAT_OFF;
            step_q <= 3'h0;
            lamp <= 1'b0;
        end else begin
            pat_q <= pat;
            step_q <= step_d;
            lamp <= lamp_d;
        end
    end

endmodule : mfs_lamp

// ===== src/mfs_top.sv
// Modem fault supervisor: supply watch, launch retries, hang resets, lamp.
// Assumes the supply-good, module-on and hang pins are asynchronous levels
// and that commands come from logic on mclk, one per cycle at most.
`include "mfs_defines.svh"
module mfs_top import mfs_pkg::*; #(
    parameter int QTR_CYCLES = `MFS_CLK_HZ / 1000 * `MFS_QTR_MS
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic vin_ok_pin,
    input wire logic vmod_ok_pin,
    input wire logic mod_on_pin,
    input wire logic hang_pin,
    input wire mfs_cmd_t cmd,
    output mfs_resp_t resp,
    output logic mod_power_en,
    output logic mod_reset,
    output logic system_indicator_lamp
);

    // ****************************************************************
    // Derived counts, times in quarter seconds.
    // ****************************************************************

    // Window for the module supply to come back.
    localparam logic [7:0] E2_Q = 8'(`MFS_E2_WIN_S * 1000 / `MFS_QTR_MS);
    // Time without a module start before the failure is confirmed.
    localparam logic [7:0] E3_Q = 8'(`MFS_E3_CONF_S * 1000 / `MFS_QTR_MS);
    // Time a reset, with or without power, is held.
    localparam logic [7:0] HOLD_Q = 8'(`MFS_RST_HOLD_MS / `MFS_QTR_MS);
    // Launch attempts before giving up.
    localparam logic [3:0] TRIES_MAX = 4'(`MFS_LAUNCH_MAX);
    // Quarters in one minute of the hang check.
    localparam logic [7:0] QPM = 8'(`MFS_MIN_S * 1000 / `MFS_QTR_MS);

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************

    logic [3:0] pin_raw; // Raw asynchronous pins.
    logic [3:0] sync1_q; // First stage, read only by the second.
    logic [3:0] sync2_q; // Second stage, safe to use.
    logic vin_s, vmod_s, mod_on_s, hang_s; // Synchronised levels.
    // Reset levels of the stages: supplies read good, so a release fakes no fault.
    localparam logic [3:0] SYNC_IDLE = 4'h3;

    assign pin_raw = {hang_pin, mod_on_pin, vmod_ok_pin, vin_ok_pin};

    // Two flip-flops per pin before any logic reads it.
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                sync1_q[i] <= SYNC_IDLE[i];
                sync2_q[i] <= SYNC_IDLE[i];
            end else begin
                sync1_q[i] <= pin_raw[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end

    assign vin_s = sync2_q[0];
    assign vmod_s = sync2_q[1];
    assign mod_on_s = sync2_q[2];
    assign hang_s = sync2_q[3];

    // ****************************************************************
    // Timebase and lamp.
    // ****************************************************************

    logic qtick; // Quarter-second pulse.
    mfs_pat_t pat; // Lamp pattern chosen from the state.

    mfs_timebase #(
        .QTR_CYCLES(QTR_CYCLES)
    ) u_tb (
        .mclk(mclk),
        .reset_n(reset_n),
        .qtick(qtick),
        .min_tick()
    );

    mfs_lamp u_lamp (
        .mclk(mclk),
        .reset_n(reset_n),
        .pat(pat),
        .qtick(qtick),
        .lamp(system_indicator_lamp)
    );

    // ****************************************************************
    // Supervisor state.
    // ****************************************************************

    mfs_state_t st_q, st_d; // Main state.
    logic [7:0] tmr_q, tmr_d; // Quarters spent in the current state.
    logic [3:0] tries_q, tries_d; // Failed launch attempts.
    logic e3_q, e3_d; // A launch failure has been confirmed.
    mfs_pat_t cause_q, cause_d; // Pattern held in waiting mode.
    logic cut_q, cut_d; // Current reset removes module power.
    logic rtype_q, rtype_d; // Reset type setting.
    logic [7:0] ival_q, ival_d; // Hang-check interval in minutes.
    logic [7:0] min_q, min_d; // Minutes since the last hang check.
    logic [7:0] qmin_q, qmin_d; // Quarters into the current check minute.
    mfs_resp_t resp_d; // Next answer.
    logic pwr_d, mrst_d; // Next module power and reset levels.
    logic do_rst; // A reset of the selected type is wanted.

    // Lamp pattern: emergency states are exclusive, and the lower
    // numbered one is tested first when a launch failure is pending.
    always_comb begin
        if (st_q == ST_WAIT) begin
            pat = cause_q;
        end else if (st_q == ST_EMER1) begin
            pat = PAT_STEADY;
        end else if (st_q == ST_EMER2) begin
            pat = PAT_BLINK2;
        end else if (e3_q) begin
            pat = PAT_BLINK3;
        end else begin
            pat = PAT_OFF;
        end
    end

    // ****************************************************************
    // Next-state logic: commands, hang check, emergencies.
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        tmr_d = (qtick && tmr_q != 8'hff) ? tmr_q + 8'h1 : tmr_q;
        tries_d = tries_q;
        e3_d = e3_q;
        cause_d = cause_q;
        cut_d = cut_q;
        rtype_d = rtype_q;
        ival_d = ival_q;
        min_d = min_q;
        qmin_d = qmin_q;
        resp_d = '0;
        do_rst = 1'b0;

        // Commands are answered in every state, the next cycle.
        if (cmd.valid) begin
            case (cmd.kind)
                CMD_SET_RTYPE: begin
                    rtype_d = cmd.arg[0];
                    resp_d = '{valid: 1'b1, data: {7'h00, cmd.arg[0]}};
                end
                CMD_GET_RTYPE: resp_d = '{valid: 1'b1, data: {7'h00, rtype_q}};
                CMD_SET_IVAL: begin
                    ival_d = cmd.arg;
                    min_d = 8'h00;
                    qmin_d = 8'h00;
                    resp_d = '{valid: 1'b1, data: cmd.arg};
                end
                CMD_GET_IVAL: resp_d = '{valid: 1'b1, data: ival_q};
                CMD_DO_RESET: begin
                    do_rst = 1'b1;
                    resp_d = '{valid: 1'b1, data: {7'h00, rtype_q}};
                end
                default: resp_d = '0;
            endcase
        end

        // Periodic hang check, counted from entry to normal running.
        if (st_q != ST_RUN || ival_q == 8'h00) begin
            min_d = 8'h00;
            qmin_d = 8'h00;
        end else if (qtick) begin
            if (qmin_q != QPM - 8'h1) begin
                qmin_d = qmin_q + 8'h1;
            end else if (min_q + 8'h1 >= ival_q) begin
                qmin_d = 8'h00;
                min_d = 8'h00;
                do_rst = do_rst | hang_s;
            end else begin
                qmin_d = 8'h00;
                min_d = min_q + 8'h1;
            end
        end

        case (st_q)
            // Normal operation with the module running.
            ST_RUN: begin
                if (!vmod_s) begin
                    st_d = ST_EMER2;
                end else if (!mod_on_s) begin
                    // Module dropped out: relaunch with a power cycle.
                    st_d = ST_RST;
                    cut_d = 1'b1;
                end else if (do_rst) begin
                    cut_d = rtype_q;
                    st_d = ST_RST;
                end
            end
            // Reset held for a fixed time, then relaunch.
            ST_RST: begin
                if (tmr_q >= HOLD_Q) begin
                    st_d = ST_LAUNCH;
                end
            end
            // Module powered, waiting for it to report it is on.
            ST_LAUNCH: begin
                if (!vmod_s) begin
                    st_d = ST_EMER2;
                end else if (mod_on_s) begin
                    st_d = ST_RUN;
                    tries_d = 4'h0;
                    e3_d = 1'b0;
                end else if (tmr_q >= E3_Q) begin
                    e3_d = 1'b1;
                    tries_d = tries_q + 4'h1;
                    if (tries_q + 4'h1 >= TRIES_MAX) begin
                        st_d = ST_WAIT;
                        cause_d = PAT_BLINK3;
                    end else begin
                        st_d = ST_RST;
                        cut_d = 1'b1;
                    end
                end
            end
            // Input supply fault: wait for it to return.
            ST_EMER1: begin
                if (vin_s) begin
                    st_d = ST_RST;
                    cut_d = 1'b1;
                end
            end
            // Module supply fault: short recovery window.
            ST_EMER2: begin
                if (vmod_s && tmr_q < E2_Q) begin
                    st_d = ST_LAUNCH;
                end else if (tmr_q >= E2_Q && vin_s) begin
                    st_d = ST_WAIT;
                    cause_d = PAT_BLINK2;
                end
            end
            ST_WAIT: st_d = ST_WAIT;
            default: st_d = ST_LAUNCH;
        endcase

        if (!vin_s && st_q != ST_WAIT && st_q != ST_EMER1) begin
            st_d = ST_EMER1;
        end

        // The state timer restarts on every state change.
        if (st_d != st_q) begin
            tmr_d = 8'h00;
        end

        // Power off in emergencies one and two and in waiting mode; kept on for type 0.
        pwr_d = (st_d == ST_RUN) || (st_d == ST_LAUNCH) || (st_d == ST_RST && !cut_d);
        mrst_d = (st_d == ST_RST) && !cut_d;
    end

    // Register all supervisor state and outputs.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_LAUNCH;
            tmr_q <= 8'h00;
            tries_q <= 4'h0;
            e3_q <= 1'b0;
            cause_q <= PAT_OFF;
            cut_q <= 1'b1;
            rtype_q <= `MFS_RTYPE_RST;
            ival_q <= `MFS_IVAL_RST;
            min_q <= 8'h00;
            qmin_q <= 8'h00;
            resp <= '0;
            mod_power_en <= 1'b0;
            mod_reset <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            tries_q <= tries_d;
            e3_q <= e3_d;
            cause_q <= cause_d;
            cut_q <= cut_d;
            rtype_q <= rtype_d;
            ival_q <= ival_d;
            min_q <= min_d;
            qmin_q <= qmin_d;
            resp <= resp_d;
            mod_power_en <= pwr_d;
            mod_reset <= mrst_d;
        end
    end

endmodule : mfs_top

// ===== verification/mfs_checker.sv
// Concurrent checks on the ports of the modem fault supervisor.
// Assumes it is bound onto mfs_top and that everything runs on mclk.
module mfs_checker import mfs_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic vin_ok_pin,
    input wire logic vmod_ok_pin,
    input wire logic mod_on_pin,
    input wire logic hang_pin,
    input wire mfs_cmd_t cmd,
    input wire mfs_resp_t resp,
    input wire logic mod_power_en,
    input wire logic mod_reset,
    input wire logic system_indicator_lamp
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // High when a command of an answered kind is offered.
    logic known;
    assign known = cmd.valid && (cmd.kind inside {CMD_SET_RTYPE, CMD_GET_RTYPE, CMD_SET_IVAL,
        CMD_GET_IVAL, CMD_DO_RESET});
    a_resp_after_cmd: assert property (known |=> resp.valid) else $error("command not answered");
    a_resp_quiet: assert property (!known |=> !resp.valid) else $error("answer without command");
    a_rtype_echo: assert property ((known && cmd.kind == CMD_SET_RTYPE) |=>
        resp.data == {7'h00, $past(cmd.arg[0])}) else $error("reset type echo wrong");
    a_ival_echo: assert property ((known && cmd.kind == CMD_SET_IVAL) |=>
        resp.data == $past(cmd.arg)) else $error("interval echo wrong");
    a_rtype_bit: assert property ((known && cmd.kind == CMD_GET_RTYPE) |=>
        resp.data[7:1] == 7'h00) else $error("reset type not a single bit");
    a_vin_cut: assert property (!vin_ok_pin [*6] |-> !mod_power_en) else $error("power on with bad input");
    a_vmod_cut: assert property (!vmod_ok_pin [*6] |-> !mod_power_en) else $error("power on with bad supply");
    a_reset_power: assert property (mod_reset |-> mod_power_en) else $error("soft reset without power");
    a_lamp_off_min: assert property ($fell(system_indicator_lamp) |=>
        !system_indicator_lamp [*7]) else $error("lamp dark phase too short");
    // Main scenarios reached.
    c_hang_reset: cover property ($rose(mod_reset));
    c_lamp_lit: cover property ($rose(system_indicator_lamp));
    c_answer: cover property (resp.valid);
endmodule : mfs_checker

// ===== verification/mfs_gsm_model.sv
// Behavioural radio module on the far side of the supervisor.
// Assumes power and reset come from the supervisor on mclk.
module mfs_gsm_model #(
    parameter int START_CYC = 20
) (
    input wire logic mclk,
    input wire logic mod_power_en,
    input wire logic mod_reset,
    input wire logic present,
    input wire logic hang,
    output logic mod_on_pin,
    output logic hang_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Cycles spent powered and out of reset; an absent module never starts.
    int up_cnt = 0;
    always_ff @(posedge mclk) begin
        if (!mod_power_en || mod_reset || !present) begin
            up_cnt <= 0;
        end else if (up_cnt < START_CYC) begin
            up_cnt <= up_cnt + 1;
        end
    end
    // The module reports running once its boot time has passed.
    assign mod_on_pin = (up_cnt >= START_CYC);
    // A hang is only visible from a running module.
    assign hang_pin = mod_on_pin && hang;
endmodule : mfs_gsm_model

// ===== verification/mfs_top_tb.sv
// Self-checking bench of the modem fault supervisor with a radio model.
// Assumes a quarter second shortened to 8 cycles of mclk.
module mfs_top_tb import mfs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
        $display("[ERR] %s exp=%0h got=%0h", nm, e, g); mismatches++; end end
    `define WAIT_UNTIL(c, lim) for (w = 0; w < (lim) && !(c); w++) @(negedge mclk);
    // One command with the answer it should give.
    typedef struct {mfs_cmd_kind_t kind; logic [7:0] arg; logic vld; logic [7:0] exp;} mfs_row_t;
    logic mclk, reset_n, vin_ok_pin, vmod_ok_pin, mod_on_pin, hang_pin, present, hang, p;
    logic mod_power_en, mod_reset, system_indicator_lamp;
    mfs_cmd_t cmd;
    mfs_resp_t resp, r;
    int mismatches = 0, cmp_count = 0, w, n, k;
    mfs_row_t rows [10] = '{'{CMD_SET_RTYPE, 8'h00, 1'b1, 8'h00}, '{CMD_GET_RTYPE, 8'h00, 1'b1, 8'h00},
        '{CMD_SET_RTYPE, 8'hff, 1'b1, 8'h01}, '{CMD_GET_RTYPE, 8'h00, 1'b1, 8'h01},
        '{CMD_SET_IVAL, 8'hff, 1'b1, 8'hff}, '{CMD_GET_IVAL, 8'h00, 1'b1, 8'hff},
        '{CMD_SET_IVAL, 8'h00, 1'b1, 8'h00}, '{CMD_NOP, 8'h5a, 1'b0, 8'h00},
        '{CMD_GET_IVAL, 8'h00, 1'b1, 8'h00}, '{CMD_DO_RESET, 8'h00, 1'b1, 8'h01}};
    mfs_top #(.QTR_CYCLES(8)) dut (.mclk(mclk), .reset_n(reset_n), .vin_ok_pin(vin_ok_pin),
        .vmod_ok_pin(vmod_ok_pin), .mod_on_pin(mod_on_pin), .hang_pin(hang_pin), .cmd(cmd), .resp(resp),
        .mod_power_en(mod_power_en), .mod_reset(mod_reset), .system_indicator_lamp(system_indicator_lamp));
    mfs_gsm_model u_gsm (.mclk(mclk), .mod_power_en(mod_power_en), .mod_reset(mod_reset), .present(present),
        .hang(hang), .mod_on_pin(mod_on_pin), .hang_pin(hang_pin));
    // 50 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Strobe one command for a cycle and pick up its answer.
    task automatic send(input mfs_cmd_kind_t kd, input logic [7:0] a, output mfs_resp_t ans);
        @(negedge mclk);
        cmd = {1'b1, kd, a};
        @(negedge mclk);
        cmd = '0;
        ans = resp;
    endtask : send
    // Length in cycles of the lamp run at the given level.
    task automatic run_len(input logic lvl, output int len);
        len = 0;
        while (system_indicator_lamp === lvl && len < 200) begin
            len++;
            @(negedge mclk);
        end
    endtask : run_len
    // Wait for the module to run and the supervisor to settle.
    task automatic wait_up(input string nm);
        `WAIT_UNTIL(mod_on_pin === 1'b1 && mod_power_en === 1'b1 && mod_reset === 1'b0, 700)
        `CHK(nm, 1'b1, mod_on_pin)
        repeat (6) @(negedge mclk);
    endtask : wait_up
    // Print the counts and the verdict, then stop.
    task automatic test_done;
        $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        test_done();
    end
    // Main sequence.
    initial begin
        reset_n = 1'b0; vin_ok_pin = 1'b1; vmod_ok_pin = 1'b1; present = 1'b1; hang = 1'b0; cmd = '0;
        repeat (2) @(negedge mclk);
        `CHK("power_rst", 1'b0, mod_power_en)
        `CHK("lamp_rst", 1'b0, system_indicator_lamp)
        `CHK("resp_rst", 1'b0, resp.valid)
        reset_n = 1'b1;
        wait_up("start");
        foreach (rows[i]) begin
            send(rows[i].kind, rows[i].arg, r);
            `CHK("resp_valid", rows[i].vld, r.valid)
            if (rows[i].vld) `CHK("resp_data", rows[i].exp, r.data)
        end
        `WAIT_UNTIL(mod_power_en === 1'b0, 6)
        `CHK("rst1_cut", 1'b0, mod_power_en)
        wait_up("rst1_up");
        // hang check at one minute, type zero
        send(CMD_SET_RTYPE, 8'h00, r);
        send(CMD_SET_IVAL, 8'h01, r);
        hang = 1'b1;
        `WAIT_UNTIL(mod_reset === 1'b1, 2200)
        `CHK("hang_rst", 1'b1, mod_reset)
        `CHK("hang_late", 1'b1, w > 1880)
        `CHK("rst0_power", 1'b1, mod_power_en)
        hang = 1'b0;
        wait_up("rst0_up");
        send(CMD_SET_IVAL, 8'h00, r);
        hang = 1'b1;
        `WAIT_UNTIL(mod_reset === 1'b1 || mod_power_en !== 1'b1, 2100)
        `CHK("ival_off", 2100, w)
        hang = 1'b0;
        // steady lamp in the first emergency
        vin_ok_pin = 1'b0;
        repeat (8) @(negedge mclk);
        k = 0;
        repeat (60) begin
            @(negedge mclk);
            k += (mod_power_en !== 1'b0) + (system_indicator_lamp !== 1'b1);
        end
        `CHK("emer1", 0, k)
        vin_ok_pin = 1'b1;
        wait_up("emer1_back");
        // symmetric blink in the second emergency
        vmod_ok_pin = 1'b0;
        `WAIT_UNTIL(system_indicator_lamp === 1'b1, 40)
        run_len(1'b1, n);
        run_len(1'b0, n);
        `CHK("blink2_off", 16, n)
        run_len(1'b1, n);
        `CHK("blink2_on", 16, n)
        `CHK("emer2_cut", 1'b0, mod_power_en)
        vmod_ok_pin = 1'b1;
        wait_up("emer2_back");
        present = 1'b0;
        send(CMD_DO_RESET, 8'h00, r);
        `WAIT_UNTIL(system_indicator_lamp === 1'b1, 440)
        `CHK("e3_early", 440, w)
        `WAIT_UNTIL(system_indicator_lamp === 1'b1, 200)
        run_len(1'b1, n);
        run_len(1'b0, n);
        `CHK("p3_off1", 8, n)
        run_len(1'b1, n);
        `CHK("p3_on2", 8, n)
        run_len(1'b0, n);
        `CHK("p3_off2", 32, n)
        present = 1'b1;
        wait_up("e3_back");
        repeat (34) @(negedge mclk);
        `CHK("e3_lamp_off", 1'b0, system_indicator_lamp)
        // ten failed launches lead to waiting; type one makes the first launch a power-up, retries always are
        send(CMD_SET_RTYPE, 8'h01, r);
        present = 1'b0;
        send(CMD_DO_RESET, 8'h00, r);
        p = mod_power_en;
        k = 0;
        n = 0;
        for (w = 0; w < 8000 && n < 100; w++) begin
            @(negedge mclk);
            k += (mod_power_en === 1'b1 && p === 1'b0);
            n = (mod_power_en === 1'b0) ? n + 1 : 0;
            p = mod_power_en;
        end
        `CHK("launches", 10, k)
        `CHK("wait_in", 100, n)
        // nothing but power-on reset leaves waiting
        present = 1'b1;
        vin_ok_pin = 1'b0;
        repeat (30) @(negedge mclk);
        vin_ok_pin = 1'b1;
        k = 0;
        n = 0;
        repeat (600) begin
            @(negedge mclk);
            k += (mod_power_en !== 1'b0);
            n += (system_indicator_lamp === 1'b1);
        end
        `CHK("wait_hold", 0, k)
        `CHK("wait_lamp", 1'b1, n > 0)
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        wait_up("por_out");
        // module supply not back in time
        vmod_ok_pin = 1'b0;
        repeat (400) @(negedge mclk);
        vmod_ok_pin = 1'b1;
        repeat (200) @(negedge mclk);
        `CHK("e2_wait", 1'b0, mod_power_en)
        `WAIT_UNTIL(system_indicator_lamp === 1'b1, 40)
        run_len(1'b1, n);
        run_len(1'b0, n);
        `CHK("e2_wait_lamp", 16, n)
        test_done();
    end
endmodule : mfs_top_tb
bind mfs_top mfs_checker u_chk (.mclk(mclk), .reset_n(reset_n), .vin_ok_pin(vin_ok_pin),
    .vmod_ok_pin(vmod_ok_pin), .mod_on_pin(mod_on_pin), .hang_pin(hang_pin), .cmd(cmd), .resp(resp),
    .mod_power_en(mod_power_en), .mod_reset(mod_reset), .system_indicator_lamp(system_indicator_lamp));
